// file: pcd_consts.vh
`ifndef PCD_CONSTS_VH
`define PCD_CONSTS_VH
// Register byte addresses
`define PCD_ADDR_CFG_WORD    12'h000
`define PCD_ADDR_CFG_ALT     12'h004
`define PCD_ADDR_DECODE      12'h008
`define PCD_ADDR_STATUS      12'h00c
`define PCD_ADDR_SELECT      12'h010
// Configuration word fields
`define PCD_USB_FSEL_BIT     30
`define PCD_ODIV_MSB         18
`define PCD_ODIV_LSB         16
`define PCD_MULT_MSB         14
`define PCD_MULT_LSB         8
`define PCD_ICLK_BIT         7
`define PCD_RNG_MSB          6
`define PCD_RNG_LSB          4
// Bits 31, 29..19 and 15 must be programmed as one
`define PCD_RSVD_MASK        32'hbff88000
// Range codes
`define PCD_RNG_BYPASS       3'h0
`define PCD_RNG_MAX_VALID    3'h5
// Reset values
`define PCD_WORD_RESET       32'hffffffff
// Decode of the all-ones word, shown while reset is held
`define PCD_FSEL_RESET       1'b1
`define PCD_ODIV_RESET       6'h20
`define PCD_MULT_RESET       8'h80
`define PCD_ICLK_RESET       1'b1
`define PCD_RNG_RESET        3'h7
// AXI responses
`define PCD_RESP_OKAY        2'h0
`define PCD_RESP_SLVERR      2'h2
`endif

// file: pcd_odiv_decode.v
`timescale 1ns/1ps
`default_nettype none
module pcd_odiv_decode (
  input  wire [2:0] code,
  output reg  [5:0] divisor
);
  always @* begin
    case (code)
      3'h0, 3'h1: divisor = 6'h02;
      3'h2:       divisor = 6'h04;
      3'h3:       divisor = 6'h08;
      3'h4:       divisor = 6'h10;
      default:    divisor = 6'h20;
    endcase
  end
endmodule
`default_nettype wire

// file: pcd_pll_config.v
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pcd_consts.vh"
module pcd_pll_config (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [31:0] cfg_word_in,
  input  wire [31:0] cfg_word_alt_in,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         usb_pll_input_freq_select,
  output reg  [5:0]  sys_pll_output_divisor,
  output reg  [7:0]  sys_pll_feedback_multiplier,
  output reg         sys_pll_input_source_select,
  output reg  [2:0]  sys_pll_input_range,
  output reg         sys_pll_bypass,
  output reg         cfg_range_reserved,
  output reg         cfg_reserved_bits_bad
);
  // Configuration words come from nonvolatile storage, so they are synchronised
  reg  [31:0] prim_s1_q;
  reg  [31:0] prim_s2_q;
  reg  [31:0] alt_s1_q;
  reg  [31:0] alt_s2_q;
  reg  [31:0] word_q;
  reg  [31:0] alt_q;
  reg         captured_q;
  reg         cap_cnt_q;
  reg         use_alt_q;
  reg         use_alt_pend_q;
  wire [31:0] sel_word;
  wire [5:0]  odiv_dec;
  wire [2:0]  rng_code;

  always @(posedge aclk) begin
    prim_s1_q <= cfg_word_in;
    prim_s2_q <= prim_s1_q;
    alt_s1_q  <= cfg_word_alt_in;
    alt_s2_q  <= alt_s1_q;
  end

  assign sel_word = use_alt_q ? alt_q : word_q;
  assign rng_code = sel_word[`PCD_RNG_MSB:`PCD_RNG_LSB];

  pcd_odiv_decode i_pcd_odiv_decode (
    .code    (sel_word[`PCD_ODIV_MSB:`PCD_ODIV_LSB]),
    .divisor (odiv_dec)
  );

  // Capture waits two cycles after release so the synchroniser holds the word
  always @(posedge aclk) begin
    if (!aresetn) begin
      word_q     <= `PCD_WORD_RESET;
      alt_q      <= `PCD_WORD_RESET;
      captured_q <= 1'b0;
      cap_cnt_q  <= 1'b0;
      use_alt_q  <= 1'b0;
    end else begin
      if (!captured_q) begin
        cap_cnt_q <= 1'b1;
        if (cap_cnt_q) begin
          word_q     <= prim_s2_q;
          alt_q      <= alt_s2_q;
          captured_q <= 1'b1;
          use_alt_q  <= use_alt_pend_q;
        end
      end
    end
  end

  // Decoded settings only change at capture, so they stay fixed until reset
  always @(posedge aclk) begin
    if (!aresetn) begin
      usb_pll_input_freq_select   <= `PCD_FSEL_RESET;
      sys_pll_output_divisor      <= `PCD_ODIV_RESET;
      sys_pll_feedback_multiplier <= `PCD_MULT_RESET;
      sys_pll_input_source_select <= `PCD_ICLK_RESET;
      sys_pll_input_range         <= `PCD_RNG_RESET;
      sys_pll_bypass              <= 1'b0;
      cfg_range_reserved          <= 1'b1;
      cfg_reserved_bits_bad       <= 1'b0;
    end else begin
      usb_pll_input_freq_select   <= sel_word[`PCD_USB_FSEL_BIT];
      sys_pll_output_divisor      <= odiv_dec;
      sys_pll_feedback_multiplier <= {1'b0, sel_word[`PCD_MULT_MSB:`PCD_MULT_LSB]} + 8'h01;
      sys_pll_input_source_select <= sel_word[`PCD_ICLK_BIT];
      sys_pll_input_range         <= rng_code;
      sys_pll_bypass              <= rng_code == `PCD_RNG_BYPASS;
      // Reserved codes are flagged so software can spot a badly programmed word
      cfg_range_reserved          <= rng_code > `PCD_RNG_MAX_VALID;
      // Flag a word that the programmer left with a reserved bit cleared
      cfg_reserved_bits_bad <= (sel_word & `PCD_RSVD_MASK) != `PCD_RSVD_MASK;
    end
  end

  // AXI4-Lite write: only the select register is writable, used at the capture after a one-cycle reset
  reg  [11:0] aw_addr_q;
  reg         aw_have_q;
  reg  [31:0] w_data_q;
  reg         w_have_q;
  reg  [3:0]  w_strb_q;

  // Response and select update share one decode so they can never disagree
  function sel_hit;
    input [11:0] addr;
    begin
      sel_hit = ({addr[11:2], 2'b00} == `PCD_ADDR_SELECT);
    end
  endfunction

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready  <= 1'b1;
      s_axi_wready   <= 1'b1;
      s_axi_bvalid   <= 1'b0;
      s_axi_bresp    <= `PCD_RESP_OKAY;
      aw_have_q      <= 1'b0;
      w_have_q       <= 1'b0;
      aw_addr_q      <= 12'h000;
      w_data_q       <= 32'h00000000;
      w_strb_q       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q     <= s_axi_awaddr;
        aw_have_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        w_have_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_have_q && w_have_q && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        if (sel_hit(aw_addr_q)) begin
          s_axi_bresp <= `PCD_RESP_OKAY;
        end else begin
          s_axi_bresp <= `PCD_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Select bit survives only a one-cycle reset; a reset held two or more cycles clears it. It chooses which word the next capture uses
  always @(posedge aclk) begin
    if (!aresetn && !captured_q && !cap_cnt_q) begin
      use_alt_pend_q <= 1'b0;
    end else if (aw_have_q && w_have_q && !s_axi_bvalid &&
                 sel_hit(aw_addr_q) && w_strb_q[0]) begin
      use_alt_pend_q <= w_data_q[0];
    end
  end

  // AXI4-Lite read
  reg [31:0] rd_mux;
  always @* begin
    case ({s_axi_araddr[11:2], 2'b00})
      `PCD_ADDR_CFG_WORD: rd_mux = word_q;
      `PCD_ADDR_CFG_ALT:  rd_mux = alt_q;
      `PCD_ADDR_DECODE:   rd_mux = {10'h000, cfg_range_reserved, sys_pll_bypass,
                                    sys_pll_input_range, sys_pll_input_source_select,
                                    sys_pll_feedback_multiplier, sys_pll_output_divisor,
                                    usb_pll_input_freq_select, 1'b0};
      `PCD_ADDR_STATUS:   rd_mux = {30'h00000000, cfg_reserved_bits_bad, captured_q};
      `PCD_ADDR_SELECT:   rd_mux = {30'h00000000, use_alt_q, use_alt_pend_q};
      default:            rd_mux = 32'h00000000;
    endcase
  end

  // Map is dense from zero, so one compare finds every unmapped word
  wire rd_hit = ({s_axi_araddr[11:2], 2'b00} <= `PCD_ADDR_SELECT);

  // Read data is latched at the address handshake so it stays put under rvalid

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `PCD_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux;
        s_axi_rresp   <= rd_hit ? `PCD_RESP_OKAY : `PCD_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: pcd_pll_config_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcd_consts.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module pcd_pll_config_bench;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        usb_pll_input_freq_select, sys_pll_input_source_select;
  logic        sys_pll_bypass, cfg_range_reserved, cfg_reserved_bits_bad;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  sys_pll_input_range;
  logic [3:0]  s_axi_wstrb;
  logic [5:0]  sys_pll_output_divisor;
  logic [7:0]  sys_pll_feedback_multiplier;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] cfg_word_in, cfg_word_alt_in, s_axi_wdata, s_axi_rdata, lf;
  int          bad_count, comparisons;
  pcd_pll_config i_pcd_pll_config (.aclk, .aresetn, .cfg_word_in, .cfg_word_alt_in, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .usb_pll_input_freq_select, .sys_pll_output_divisor,
    .sys_pll_feedback_multiplier, .sys_pll_input_source_select, .sys_pll_input_range, .sys_pll_bypass,
    .cfg_range_reserved, .cfg_reserved_bits_bad);
  always #10 aclk = ~aclk;
  function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic [5:0] ediv(input [2:0] c);
    ediv = c < 3'h2 ? 6'h02 : c > 3'h4 ? 6'h20 : 6'h01 << c;
  endfunction
  function automatic [31:0] edec(input [31:0] w);
    edec = {10'h0, w[6:5] == 2'b11, w[6:4] == 3'h0, w[6:4], w[7], {1'b0, w[14:8]} + 8'h01,
      ediv(w[18:16]), w[30], 1'b0};
  endfunction
  task automatic rd(input [11:0] a, output [31:0] d, output [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task automatic wr(input [11:0] a, input [31:0] d, output [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic test_done;
    if (bad_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    test_done;
  end
  initial begin
    logic [31:0] w, d, exp_dec;
    logic [1:0]  r;
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, cfg_word_in, cfg_word_alt_in} = '0;
    s_axi_wstrb = 4'hf;
    lf = 32'h021c;
    for (int i = 0; i < 16; i++) begin
      lf = lfsr(lf);
      w = lf | `PCD_RSVD_MASK;
      // First eight passes sweep every divisor and range code, and both multiplier ends
      if (i < 8) w = {w[31:19], i[2:0], w[15], {7{i[0]}}, w[7], i[2:0], w[3:0]};
      // Last pass breaks the reserved-ones rule on purpose so the flag is seen raised
      if (i == 15) w[15] = 1'b0;
      exp_dec = edec(w);
      @(posedge aclk);
      aresetn <= 0;
      cfg_word_in <= w;
      cfg_word_alt_in <= ~w;
      repeat (12) @(posedge aclk);
      `CHK({usb_pll_input_freq_select, sys_pll_output_divisor}, {1'b1, 6'h20})
      `CHK({sys_pll_feedback_multiplier, sys_pll_input_source_select}, {8'h80, 1'b1})
      `CHK({sys_pll_input_range, sys_pll_bypass, cfg_range_reserved, cfg_reserved_bits_bad}, 6'h3a)
      `CHK({s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid}, 5'h1c)
      aresetn <= 1;
      repeat (4) @(posedge aclk);
      `CHK(usb_pll_input_freq_select, w[30])
      `CHK(sys_pll_output_divisor, ediv(w[18:16]))
      `CHK(sys_pll_feedback_multiplier, {1'b0, w[14:8]} + 8'h01)
      `CHK(sys_pll_input_source_select, w[7])
      `CHK({cfg_range_reserved, sys_pll_bypass, sys_pll_input_range}, exp_dec[21:17])
      `CHK(cfg_reserved_bits_bad, (w & `PCD_RSVD_MASK) != `PCD_RSVD_MASK)
      rd(12'h008, d, r);
      `CHK({r, d}, {`PCD_RESP_OKAY, exp_dec})
      // A long reset clears the pending select, so the primary word stays in use
      rd(`PCD_ADDR_SELECT, d, r);
      `CHK({r, d}, {`PCD_RESP_OKAY, 32'h0})
      s_axi_wstrb <= w[11:8];
      wr(`PCD_ADDR_SELECT, 32'h1, r);
      `CHK(r, `PCD_RESP_OKAY)
      rd(`PCD_ADDR_SELECT, d, r);
      `CHK({r, d}, {`PCD_RESP_OKAY, 30'h0, 1'b0, w[8]})
      rd(`PCD_ADDR_CFG_ALT, d, r);
      `CHK({r, d}, {`PCD_RESP_OKAY, ~w})
      rd(`PCD_ADDR_STATUS, d, r);
      `CHK({r, d}, {`PCD_RESP_OKAY, 30'h0, (w & `PCD_RSVD_MASK) != `PCD_RSVD_MASK, 1'b1})
      wr(12'h000, ~w, r);
      `CHK(r, `PCD_RESP_SLVERR)
      rd(12'h000, d, r);
      `CHK({r, d}, {`PCD_RESP_OKAY, w})
      rd(12'h020, d, r);
      `CHK({r, d}, {`PCD_RESP_SLVERR, 32'h0})
    end
    test_done;
  end
endmodule
`default_nettype wire

// file: pcd_pll_config_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcd_consts.vh"
module pcd_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [31:0] cfg_word_in,
  input wire logic        usb_pll_input_freq_select,
  input wire logic [5:0]  sys_pll_output_divisor,
  input wire logic [7:0]  sys_pll_feedback_multiplier,
  input wire logic        sys_pll_input_source_select,
  input wire logic [2:0]  sys_pll_input_range,
  input wire logic        sys_pll_bypass,
  input wire logic        cfg_range_reserved,
  input wire logic        cfg_reserved_bits_bad
);
  // Only valid while the bench keeps the word steady between resets
  wire [2:0] oc = cfg_word_in[18:16];
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  usb_fsel_a: assert property (aresetn[*4] |-> usb_pll_input_freq_select == cfg_word_in[30])
    else $error("usb pll select wrong");
  out_div_a: assert property (aresetn[*4] |->
    sys_pll_output_divisor == (oc < 3'h2 ? 6'h02 : oc > 3'h4 ? 6'h20 : 6'h01 << oc))
    else $error("output divisor wrong");
  fb_mult_a: assert property (aresetn[*4] |-> sys_pll_feedback_multiplier == cfg_word_in[14:8] + 8'h01)
    else $error("multiplier wrong");
  in_src_a: assert property (aresetn[*4] |-> sys_pll_input_source_select == cfg_word_in[7])
    else $error("input source wrong");
  in_range_a: assert property (aresetn[*4] |-> sys_pll_input_range == cfg_word_in[6:4])
    else $error("input range wrong");
  range_flags_a: assert property (aresetn[*4] |->
    sys_pll_bypass == (cfg_word_in[6:4] == 3'h0) && cfg_range_reserved == (cfg_word_in[6:4] > 3'h5))
    else $error("range flags wrong");
  rsvd_flag_a: assert property (aresetn[*4] |->
    cfg_reserved_bits_bad == ((cfg_word_in & `PCD_RSVD_MASK) != `PCD_RSVD_MASK)) else $error("flag wrong");
  cfg_hold_a: assert property (aresetn[*5] |->
    $stable({usb_pll_input_freq_select, sys_pll_output_divisor, sys_pll_feedback_multiplier,
             sys_pll_input_source_select, sys_pll_input_range, sys_pll_bypass, cfg_range_reserved,
             cfg_reserved_bits_bad}))
    else $error("settings moved");
endmodule
bind pcd_pll_config pcd_props i_pcd_props (.aclk, .aresetn, .cfg_word_in, .usb_pll_input_freq_select,
  .sys_pll_output_divisor, .sys_pll_feedback_multiplier, .sys_pll_input_source_select,
  .sys_pll_input_range, .sys_pll_bypass, .cfg_range_reserved, .cfg_reserved_bits_bad);
`default_nettype wire
